// ===== core/gpa_pkg.sv
// Purpose: shared constants of the gpio port access block
// Assumes: 18-pin port, 32-bit AXI4-Lite register bus
// Notes:   offsets are byte addresses inside the block
package gpa_pkg;
  localparam int unsigned NPINS      = 18;
  localparam int unsigned AW         = 14;
  localparam int unsigned DW         = 32;
  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [13:0] BYTE_PIN_BASE  = 14'h0000;
  localparam logic [13:0] WORD_PIN_BASE  = 14'h1000;
  localparam logic [13:0] DIRECTION_OFF  = 14'h2000;
  localparam logic [13:0] MASK_OFF       = 14'h2080;
  localparam logic [13:0] PORT_OFF       = 14'h2100;
  localparam logic [13:0] MASKED_VIEW_OFF = 14'h2180;
  localparam logic [13:0] OUT_SET_OFF    = 14'h2200;
  localparam logic [13:0] OUT_CLEAR_OFF  = 14'h2280;
  localparam logic [13:0] OUT_TOGGLE_OFF = 14'h2300;
  localparam logic [13:0] DIR_SET_OFF    = 14'h2380;
  localparam logic [13:0] DIR_CLEAR_OFF  = 14'h2400;
  localparam logic [13:0] DIR_TOGGLE_OFF = 14'h2480;
  // -------------------------------------------------------------
  // reset values and responses
  // -------------------------------------------------------------
  localparam logic [17:0] OUT_RST   = 18'h00000;
  localparam logic [17:0] DIR_RST   = 18'h00000;
  localparam logic [17:0] MASK_RST  = 18'h00000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : gpa_pkg

// ===== core/gpa_sync.sv
// Purpose: two-flop synchroniser for the pin inputs
// Assumes: inputs are asynchronous to clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module gpa_sync (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic [gpa_pkg::NPINS-1:0]   async_in,
  output var  logic [gpa_pkg::NPINS-1:0]   sync_out
);
  logic [gpa_pkg::NPINS-1:0] stage1;

  for (genvar i = 0; i < gpa_pkg::NPINS; i++) begin : g_bit
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        stage1[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        stage1[i]   <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  end
endmodule : gpa_sync
`default_nettype wire

// ===== core/gpa_port.sv
// Purpose: gpio port access logic behind an AXI4-Lite slave
// Assumes: one clock, pins asynchronous, pin routing flags same-clock
// Notes:   one write and one read in flight; no interrupt logic
//
// Notes on behaviour
// - byte pin read: level in bit0, rest zero
// - word pin read: level replicated in all bits
// - port read returns all pin levels, analog pins reading zero
// - masked view reads zero where mask set
// - levels readable whatever function; analog pins excluded
// - drive pin only if gpio-routed and direction one
// - byte pin write loads output from lsb
// - word pin write loads OR of data
// - port write loads outputs in written lanes
// - masked view write skips masked outputs
// - set register sets outputs, ignores mask
// - output_clear register clears outputs written one
// - toggle register inverts outputs written one
// - set register read returns output bits
// - pin views ignore direction and alternate function
// - zero mask makes masked view equal port
// - direction bits with set, clear, toggle views
// - pins 17:0, bits 31:18 read zero except in word pin reads
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module gpa_port (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  // AXI4-Lite slave
  input  wire logic [gpa_pkg::AW-1:0]      s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output var  logic                        s_axi_awready,
  input  wire logic [gpa_pkg::DW-1:0]      s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output var  logic                        s_axi_wready,
  output var  logic [1:0]                  s_axi_bresp,
  output var  logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [gpa_pkg::AW-1:0]      s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output var  logic                        s_axi_arready,
  output var  logic [gpa_pkg::DW-1:0]      s_axi_rdata,
  output var  logic [1:0]                  s_axi_rresp,
  output var  logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // pin side
  input  wire logic [gpa_pkg::NPINS-1:0]   pin_in,
  input  wire logic [gpa_pkg::NPINS-1:0]   gpio_routed,
  input  wire logic [gpa_pkg::NPINS-1:0]   analog_sel,
  output var  logic [gpa_pkg::NPINS-1:0]   pin_out,
  output var  logic [gpa_pkg::NPINS-1:0]   pin_oe
);
  localparam int unsigned N = gpa_pkg::NPINS;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [N-1:0]               out_bits;
  logic [N-1:0]               dir_bits;
  logic [N-1:0]               mask_bits;
  logic [N-1:0]               pin_sync;
  logic                       aw_full;
  logic                       w_full;
  logic [gpa_pkg::AW-1:0]     aw_addr;
  logic [gpa_pkg::DW-1:0]     w_data;
  logic [3:0]                 w_strb;

  gpa_sync gpa_sync_inst (
    .clock    (clock),
    .arst_n   (arst_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // -------------------------------------------------------------
  // pin levels
  // -------------------------------------------------------------
  // analog pins read low: their digital receiver is not trusted
  wire [N-1:0] level = pin_sync & ~analog_sel;

  // -------------------------------------------------------------
  // write channel
  // -------------------------------------------------------------
  wire aw_hs  = s_axi_awvalid & s_axi_awready;
  wire w_hs   = s_axi_wvalid & s_axi_wready;
  wire wr_do  = aw_full & w_full & ~s_axi_bvalid;
  wire next_aw_full = (aw_full | aw_hs) & ~wr_do;
  wire next_w_full  = (w_full | w_hs) & ~wr_do;
  wire next_bvalid  = wr_do | (s_axi_bvalid & ~s_axi_bready);
  // readies stay low while a response waits: one write in flight
  wire next_awready = ~next_aw_full & ~next_bvalid;
  wire next_wready  = ~next_w_full & ~next_bvalid;

  wire [31:0] lane = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wd_l = w_data & lane;
  wire [N-1:0] bm  = lane[N-1:0];
  wire [N-1:0] wd  = wd_l[N-1:0];

  // per-pin decode: index from word address
  wire [9:0]  w_idx     = aw_addr[11:2];
  wire        w_idx_ok  = w_idx < 10'(N);
  wire [4:0]  w_pin     = w_idx[4:0];
  wire        wr_bpin   = wr_do & (aw_addr[13:12] == gpa_pkg::BYTE_PIN_BASE[13:12]) & w_idx_ok;
  wire        wr_wpin   = wr_do & (aw_addr[13:12] == gpa_pkg::WORD_PIN_BASE[13:12]) & w_idx_ok;
  wire        wr_dir    = wr_do & (aw_addr == gpa_pkg::DIRECTION_OFF);
  wire        wr_mask   = wr_do & (aw_addr == gpa_pkg::MASK_OFF);
  wire        wr_port   = wr_do & (aw_addr == gpa_pkg::PORT_OFF);
  wire        wr_mview  = wr_do & (aw_addr == gpa_pkg::MASKED_VIEW_OFF);
  wire        wr_set    = wr_do & (aw_addr == gpa_pkg::OUT_SET_OFF);
  wire        wr_clear  = wr_do & (aw_addr == gpa_pkg::OUT_CLEAR_OFF);
  wire        wr_tgl    = wr_do & (aw_addr == gpa_pkg::OUT_TOGGLE_OFF);
  wire        wr_dset   = wr_do & (aw_addr == gpa_pkg::DIR_SET_OFF);
  wire        wr_dclr   = wr_do & (aw_addr == gpa_pkg::DIR_CLEAR_OFF);
  wire        wr_dtgl   = wr_do & (aw_addr == gpa_pkg::DIR_TOGGLE_OFF);
  wire        wr_hit    = wr_bpin | wr_wpin | wr_dir | wr_mask | wr_port | wr_mview
                          | wr_set | wr_clear | wr_tgl | wr_dset | wr_dclr | wr_dtgl;

  // single-pin value and which pin it targets
  wire         bpin_val  = w_data[0];
  wire         wpin_val  = |wd_l;
  wire [N-1:0] pin_sel   = N'(1) << w_pin;
  wire         pin_en    = (wr_bpin & w_strb[0]) | (wr_wpin & (|w_strb));
  wire         pin_val   = wr_bpin ? bpin_val : wpin_val;

  // masked lanes of the masked view; zero mask equals port view
  wire [N-1:0] mview_bm  = bm & ~mask_bits;

  wire [N-1:0] out_a = wr_port  ? ((out_bits & ~bm) | (wd & bm)) :
                       wr_mview ? ((out_bits & ~mview_bm) | (wd & mview_bm)) :
                       wr_set   ? (out_bits | wd) :
                       wr_clear ? (out_bits & ~wd) :
                       wr_tgl   ? (out_bits ^ wd) :
                       out_bits;
  wire [N-1:0] next_out = pin_en ? ((out_a & ~pin_sel) | ({N{pin_val}} & pin_sel)) : out_a;

  wire [N-1:0] next_dir = wr_dir  ? ((dir_bits & ~bm) | (wd & bm)) :
                          wr_dset ? (dir_bits | wd) :
                          wr_dclr ? (dir_bits & ~wd) :
                          wr_dtgl ? (dir_bits ^ wd) :
                          dir_bits;
  wire [N-1:0] next_mask = wr_mask ? ((mask_bits & ~bm) | (wd & bm)) : mask_bits;

  // -------------------------------------------------------------
  // read channel
  // -------------------------------------------------------------
  wire ar_hs       = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);

  wire [9:0] r_idx    = s_axi_araddr[11:2];
  wire       r_idx_ok = r_idx < 10'(N);
  wire       r_lvl    = level[r_idx[4:0]];
  wire       rd_bpin  = (s_axi_araddr[13:12] == gpa_pkg::BYTE_PIN_BASE[13:12]) & r_idx_ok;
  wire       rd_wpin  = (s_axi_araddr[13:12] == gpa_pkg::WORD_PIN_BASE[13:12]) & r_idx_ok;
  wire       rd_dir   = s_axi_araddr == gpa_pkg::DIRECTION_OFF;
  wire       rd_mask  = s_axi_araddr == gpa_pkg::MASK_OFF;
  wire       rd_port  = s_axi_araddr == gpa_pkg::PORT_OFF;
  wire       rd_mview = s_axi_araddr == gpa_pkg::MASKED_VIEW_OFF;
  wire       rd_set   = s_axi_araddr == gpa_pkg::OUT_SET_OFF;
  // write-only views answer okay with zero data
  wire       rd_wo    = (s_axi_araddr == gpa_pkg::OUT_CLEAR_OFF)
                      | (s_axi_araddr == gpa_pkg::OUT_TOGGLE_OFF)
                      | (s_axi_araddr == gpa_pkg::DIR_SET_OFF)
                      | (s_axi_araddr == gpa_pkg::DIR_CLEAR_OFF)
                      | (s_axi_araddr == gpa_pkg::DIR_TOGGLE_OFF);
  wire       rd_hit   = rd_bpin | rd_wpin | rd_dir | rd_mask | rd_port | rd_mview
                        | rd_set | rd_wo;

  // upper bits stay zero for all port-wide views
  wire [N-1:0] port_v  = rd_port  ? level :
                         rd_mview ? (level & ~mask_bits) :
                         rd_set   ? out_bits :
                         rd_dir   ? dir_bits :
                         rd_mask  ? mask_bits :
                         '0;
  wire [31:0] rd_word = rd_bpin ? {31'h00000000, r_lvl} :
                        rd_wpin ? {32{r_lvl}} :
                        {14'h0000, port_v};

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  // a pin write lands last, after the port-wide views
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_bits <= gpa_pkg::OUT_RST;
    end else begin
      out_bits <= next_out;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dir_bits <= gpa_pkg::DIR_RST;
    end else begin
      dir_bits <= next_dir;
    end
  end

  // mask only gates the masked view; set, clear and toggle ignore it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mask_bits <= gpa_pkg::MASK_RST;
    end else begin
      mask_bits <= next_mask;
    end
  end

  // pin drivers registered so outputs come from flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= '0;
    end else begin
      pin_out <= out_bits;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= dir_bits & gpio_routed;
    end
  end

  // -------------------------------------------------------------
  // write channel registers
  // -------------------------------------------------------------
  // each slot holds one beat until the write is applied
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_addr <= '0;
    end else if (aw_hs) begin
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      w_data <= '0;
      w_strb <= 4'h0;
    end else if (w_hs) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpa_pkg::RESP_OKAY;
    end else begin
      s_axi_bvalid <= next_bvalid;
      if (wr_do) begin
        s_axi_bresp <= wr_hit ? gpa_pkg::RESP_OKAY : gpa_pkg::RESP_SLVERR;
      end
    end
  end

  // -------------------------------------------------------------
  // read channel registers
  // -------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
    end
  end

  // data is caught at the address handshake and stands until rready
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= gpa_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rdata <= rd_hit ? rd_word : 32'h00000000;
      s_axi_rresp <= rd_hit ? gpa_pkg::RESP_OKAY : gpa_pkg::RESP_SLVERR;
    end
  end
endmodule : gpa_port
`default_nettype wire

// ===== sim/gpa_port_asserts.sv
// Purpose: protocol and read-view checker for gpa_port
// Assumes: bound to gpa_port, one clock domain
// Notes:   keeps the last read address to judge rdata
`timescale 1ns/1ns
`default_nettype none
module gpa_port_asserts (
  input wire logic                      clock,
  input wire logic                      arst_n,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic [gpa_pkg::AW-1:0]    s_axi_araddr,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [gpa_pkg::DW-1:0]    s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic [gpa_pkg::NPINS-1:0] gpio_routed,
  input wire logic [gpa_pkg::NPINS-1:0] analog_sel,
  input wire logic [gpa_pkg::NPINS-1:0] pin_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // read address tracking
  // ----------------------------------------
  logic [13:0] rd_a;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rd_a <= 14'h0;
    else if (s_axi_arvalid && s_axi_arready) rd_a <= s_axi_araddr;
  end
  a_oe_needs_route: assert property ((pin_oe & ~$past(gpio_routed)) == 18'h0)
    else $error("pin driven while not routed");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
    else $error("read answer late");
  a_no_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_no_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_byte_pin_bits: assert property (s_axi_rvalid && rd_a[13:12] == 2'h0 |->
    s_axi_rdata[31:1] == 31'h0) else $error("byte pin read upper bits set");
  a_word_pin_fill: assert property (s_axi_rvalid && rd_a[13:12] == 2'h1 |->
    s_axi_rdata inside {32'h0, 32'hffffffff}) else $error("word pin read not replicated");
  a_reserved_zero: assert property (s_axi_rvalid && rd_a[13] |->
    s_axi_rdata[31:18] == 14'h0) else $error("reserved bits read nonzero");
  a_analog_zero: assert property (s_axi_rvalid && rd_a == gpa_pkg::PORT_OFF |->
    (s_axi_rdata[17:0] & analog_sel) == 18'h0) else $error("analog pin read nonzero");
  c_write: cover property (s_axi_bvalid);
  c_mview: cover property (s_axi_rvalid && rd_a == gpa_pkg::MASKED_VIEW_OFF);
  c_drive: cover property (pin_oe != 18'h0);
endmodule : gpa_port_asserts
`default_nettype wire

// ===== sim/gpa_pad.sv
// Purpose: pad model standing on the pin side
// Assumes: no pull on the pads
// Notes:   an undriven pad shows the outside level
`timescale 1ns/1ns
`default_nettype none
module gpa_pad (
  input  wire logic [gpa_pkg::NPINS-1:0] pin_out,
  input  wire logic [gpa_pkg::NPINS-1:0] pin_oe,
  input  wire logic [gpa_pkg::NPINS-1:0] ext_level,
  output var  logic [gpa_pkg::NPINS-1:0] pin_in
);
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : gpa_pad
`default_nettype wire

// ===== sim/gpio_port_access_logic_tb.sv
// Purpose: self-checking bench for gpa_port
// Assumes: bench is the AXI4-Lite master, gpa_pad on the pins
// Notes:   expected bus responses queued, checked by the monitor; pin_oe and pin_out checked inline
`timescale 1ns/1ns
`default_nettype none
module gpio_port_access_logic_tb;
  localparam logic [1:0] OK = gpa_pkg::RESP_OKAY;
  localparam logic [1:0] ER = gpa_pkg::RESP_SLVERR;
  logic        clock = 1'b0, arst_n = 1'b0;
  logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, d;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [17:0] gpio_routed = 18'h0, analog_sel = 18'h0, ext_level = 18'h0;
  logic [17:0] pin_in, pin_out, pin_oe, out = 18'h0, dir = 18'h0, mask = 18'h0, lm;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          num_errors = 0, n_compared = 0, cyc = 0, seed = 10756, p;
  gpa_port gpa_port_inst (.*);
  gpa_pad gpa_pad_inst (.*);
  always #20 clock = ~clock;
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [13:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] e);
    bq.push_back(e);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [13:0] a, input logic [31:0] v, input logic [1:0] e);
    rq.push_back({e, v});
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  function automatic logic [17:0] lvl();
    return ((out & dir & gpio_routed) | (ext_level & ~(dir & gpio_routed))) & ~analog_sel;
  endfunction : lvl
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (s_axi_bvalid && s_axi_bready) chk("bresp", s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (cyc == 6000) begin
      num_errors++;
      finish_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    rd(gpa_pkg::DIRECTION_OFF, 32'h0, OK);
    rd(gpa_pkg::OUT_SET_OFF, 32'h0, OK);
    rd(14'h3000, 32'h0, ER);
    wr(14'h3000, 32'hffffffff, 4'hf, ER);
    $display("reset test done");
    for (int t = 0; t < 6; t++) begin
      r = $random(seed);
      ext_level <= r[17:0];
      r = $random(seed);
      gpio_routed <= r[17:0];
      analog_sel <= t[0] ? r[31:14] : 18'h0;
      d = $random(seed);
      r = $random(seed);
      lm = {{2{r[2]}}, {8{r[1]}}, {8{r[0]}}};
      wr(gpa_pkg::PORT_OFF, d, r[3:0], OK);
      out = (out & ~lm) | (d[17:0] & lm);
      wr(gpa_pkg::DIRECTION_OFF, ~d, r[3:0], OK);
      dir = (dir & ~lm) | (~d[17:0] & lm);
      d = $random(seed);
      wr(gpa_pkg::OUT_SET_OFF, d, 4'hf, OK);
      out = out | d[17:0];
      wr(gpa_pkg::OUT_CLEAR_OFF, {d[15:0], d[31:16]}, 4'hf, OK);
      out = out & ~{d[1:0], d[31:16]};
      wr(gpa_pkg::OUT_TOGGLE_OFF, ~d, 4'hf, OK);
      out = out ^ ~d[17:0];
      r = $random(seed);
      wr(gpa_pkg::DIR_SET_OFF, r, 4'hf, OK);
      wr(gpa_pkg::DIR_CLEAR_OFF, d, 4'hf, OK);
      wr(gpa_pkg::DIR_TOGGLE_OFF, r ^ d, 4'hf, OK);
      dir = ((dir | r[17:0]) & ~d[17:0]) ^ (r[17:0] ^ d[17:0]);
      mask = (t < 2) ? 18'h0 : r[31:14];
      wr(gpa_pkg::MASK_OFF, {14'h0, mask}, 4'hf, OK);
      wr(gpa_pkg::MASKED_VIEW_OFF, d, 4'hf, OK);
      out = (out & mask) | (d[17:0] & ~mask);
      p = t * 3;
      wr(gpa_pkg::BYTE_PIN_BASE + 14'(4 * p), d, 4'h1, OK);
      out[p] = d[0];
      wr(gpa_pkg::WORD_PIN_BASE + 14'(4 * p + 4), t[0] ? 32'h0 : 32'h100 << t, 4'hf, OK);
      out[p+1] = !t[0];
      repeat (6) @(posedge clock);
      chk("pin_oe", pin_oe, dir & gpio_routed);
      chk("pin_out", pin_out, out);
      rd(gpa_pkg::OUT_SET_OFF, {14'h0, out}, OK);
      rd(gpa_pkg::DIRECTION_OFF, {14'h0, dir}, OK);
      rd(gpa_pkg::MASK_OFF, {14'h0, mask}, OK);
      rd(gpa_pkg::OUT_CLEAR_OFF, 32'h0, OK);
      lm = lvl();
      rd(gpa_pkg::PORT_OFF, {14'h0, lm}, OK);
      rd(gpa_pkg::MASKED_VIEW_OFF, {14'h0, lm & ~mask}, OK);
      rd(gpa_pkg::BYTE_PIN_BASE + 14'(4 * p), {31'h0, lm[p]}, OK);
      rd(gpa_pkg::WORD_PIN_BASE + 14'(4 * p), {32{lm[p]}}, OK);
      $display("port test %0d done", t);
    end
    @(posedge clock);
    finish_test();
  end
endmodule : gpio_port_access_logic_tb
bind gpa_port gpa_port_asserts gpa_port_asserts_inst (.*);
`default_nettype wire
